/* File: logic/lnbc_map.vh */
// Constants for the LNB supply control interface
`ifndef LNBC_MAP_VH
`define LNBC_MAP_VH
// =====================================================
// Slave address
`define LNBC_ADDR_BASE      7'h08
// =====================================================
// Register fields, first register
`define LNBC_R1_CLAMP       6
`define LNBC_R1_RANGE       5
`define LNBC_R1_TONE        4
`define LNBC_R1_CABLE       3
`define LNBC_R1_HIGHV       2
`define LNBC_R1_PWR         1
`define LNBC_R1_OVL         0
`define LNBC_R1_WMASK       8'h7E
// =====================================================
// Register fields, second register
`define LNBC_R2_OUT2        2
`define LNBC_R2_OTMP        1
`define LNBC_R2_WMASK       8'h04
`define LNBC_PICK_BIT       7
`define LNBC_REG_RESET      8'h00
// =====================================================
// Protection timing at 100 MHz
`define LNBC_CLK_MHZ        100
`define LNBC_T_OFF_MS       900
`define LNBC_T_ON_MS        20
`define LNBC_OFF_CYCLES     (`LNBC_T_OFF_MS * 1000 * `LNBC_CLK_MHZ)
`define LNBC_ON_CYCLES      (`LNBC_T_ON_MS * 1000 * `LNBC_CLK_MHZ)
`endif

/* File: logic/lnbc_sync.v */
// Two flip-flop synchroniser for an asynchronous level
`timescale 1ns/1ns
module lnbc_sync #(
	parameter [0:0] RST_VAL = 1'b1
) (
	input  wire clk,
	input  wire arst_n,
	input  wire din,
	output reg  dout
);
	reg meta_q;

	// =====================================================
	// Synchroniser chain
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_q <= RST_VAL;
			dout   <= RST_VAL;
		end else begin
			meta_q <= din;
			dout   <= meta_q;
		end
	end
endmodule

/* File: logic/lnbc_limit.v */
// Overload protection: static clamp or timed shutdown and retry
`timescale 1ns/1ns
`include "lnbc_map.vh"
module lnbc_limit #(
	parameter OFF_CYCLES = `LNBC_OFF_CYCLES,
	parameter ON_CYCLES  = `LNBC_ON_CYCLES
) (
	input  wire clk,
	input  wire arst_n,
	input  wire enable,
	input  wire static_mode,
	input  wire overload,
	output reg  flag_q,
	output reg  out_off_q
);
	localparam ST_RUN = 3'b001;
	localparam ST_OFF = 3'b010;
	localparam ST_TRY = 3'b100;

	reg [2:0]  state_q;
	reg [31:0] cnt_q;
	reg        seen_q;

	// =====================================================
	// Mode machine
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q   <= ST_RUN;
			cnt_q     <= 32'h0;
			seen_q    <= 1'b0;
			flag_q    <= 1'b0;
			out_off_q <= 1'b0;
		end else if (!enable) begin
			state_q   <= ST_RUN;
			cnt_q     <= 32'h0;
			seen_q    <= 1'b0;
			flag_q    <= 1'b0;
			out_off_q <= 1'b0;
		end else if (static_mode) begin
			state_q   <= ST_RUN;
			flag_q    <= overload;  // see R7
			out_off_q <= 1'b0;
		end else begin
			case (state_q)
			ST_RUN: begin
				if (overload) begin
					state_q   <= ST_OFF;  // see R20
					flag_q    <= 1'b1;
					out_off_q <= 1'b1;
					cnt_q     <= 32'h0;
				end
			end
			ST_OFF: begin
				if (cnt_q >= OFF_CYCLES - 1) begin
					state_q   <= ST_TRY;
					out_off_q <= 1'b0;
					cnt_q     <= 32'h0;
					seen_q    <= 1'b0;
				end else begin
					cnt_q <= cnt_q + 32'h1;
				end
			end
			ST_TRY: begin
				if (overload)
					seen_q <= 1'b1;
				if (cnt_q >= ON_CYCLES - 1) begin
					cnt_q <= 32'h0;
					if (seen_q || overload) begin
						state_q   <= ST_OFF;  // see R20
						out_off_q <= 1'b1;
					end else begin
						state_q <= ST_RUN;
						flag_q  <= 1'b0;  // see R20
					end
				end else begin
					cnt_q <= cnt_q + 32'h1;
				end
			end
			default: begin
				state_q <= ST_RUN;
			end
			endcase
		end
	end
endmodule

/* File: logic/lnbc_ctrl.v */
// I2C slave register interface for an LNB supply regulator
// Summary of operation
// R1 - Address byte MSB first, LSB is direction
// R2 - Address 0001000, or 0001001 with pin high
// R3 - Master sends address, one data byte, stop
// R4 - Data bit 7 selects which register written
// R5 - Voltage and cable bits set output level
// R6 - Tone bit zero follows gate, one continuous
// R7 - Clamp bit one static, zero timed retry
// R8 - Power bit zero disables converter and regulator
// R9 - All register bits clear at power-on
// R10 - Read shifts register copy out MSB first
// R11 - Master ack continues read, nack ends it
// R12 - Writable bits read back; flags are live
// R13 - Overtemp flag reads live shutdown state
// R14 - Overload flag reads live protection state
// R15 - Power-good low: ignore bus, clear registers
// R16 - Power-good high: interface accepts writes
// R17 - Power bit never ahead of other settings
// R18 - No acknowledge while power-good low
// R19 - Acknowledge every byte when addressed
// R20 - Dynamic: 900ms off, 20ms retry, flag
// R21 - Don't-care bits ignored, read as zero
// R22 - Read returns last written register, repeated
`timescale 1ns/1ns
`include "lnbc_map.vh"
module lnbc_ctrl #(
	parameter OFF_CYCLES = `LNBC_OFF_CYCLES,
	parameter ON_CYCLES  = `LNBC_ON_CYCLES
) (
	input  wire       clk,
	input  wire       arst_n,
	input  wire       scl_i,
	input  wire       sda_i,
	output reg        sda_o,
	output reg        sda_oe,
	input  wire       addr_sel,
	input  wire       power_good,
	input  wire       tone_gate_input,
	input  wire       overload_sense,
	input  wire       overtemp_sense,
	output reg        output_power_on,
	output reg        high_voltage_pick,
	output reg        cable_drop_boost,
	output reg        tone_on,
	output reg        static_clamp_select,
	output reg        limit_range_pick,
	output reg        second_output_on,
	output reg        overload_flag,
	output reg        overtemp_flag
);
	localparam ST_IDLE  = 6'b000001;
	localparam ST_ADDR  = 6'b000010;
	localparam ST_AACK  = 6'b000100;
	localparam ST_WDATA = 6'b001000;
	localparam ST_RDATA = 6'b010000;
	localparam ST_MACK  = 6'b100000;

	wire scl_s;
	wire sda_s;
	wire sel_s;
	wire [7:0] img_w;
	wire pg_s;
	wire gate_s;
	wire ovl_s;
	wire otp_s;
	wire lim_flag;
	wire lim_off;

	reg       scl_d_q;
	reg       sda_d_q;
	reg [5:0] state_q;
	reg [3:0] bit_q;
	reg [7:0] shift_q;
	reg       rw_q;
	reg       ack_q;
	reg       wr_q;
	reg [7:0] reg1_q;
	reg [7:0] reg2_q;
	reg       pick_q;

	// =====================================================
	// Input synchronisers
	lnbc_sync #(
		.RST_VAL (1'b1)
	) u_scl (
		.clk    (clk),
		.arst_n (arst_n),
		.din    (scl_i),
		.dout   (scl_s)
	);

	lnbc_sync #(
		.RST_VAL (1'b1)
	) u_sda (
		.clk    (clk),
		.arst_n (arst_n),
		.din    (sda_i),
		.dout   (sda_s)
	);

	lnbc_sync #(
		.RST_VAL (1'b0)
	) u_sel (
		.clk    (clk),
		.arst_n (arst_n),
		.din    (addr_sel),
		.dout   (sel_s)
	);

	lnbc_sync #(
		.RST_VAL (1'b0)
	) u_pg (
		.clk    (clk),
		.arst_n (arst_n),
		.din    (power_good),
		.dout   (pg_s)
	);

	lnbc_sync #(
		.RST_VAL (1'b0)
	) u_gt (
		.clk    (clk),
		.arst_n (arst_n),
		.din    (tone_gate_input),
		.dout   (gate_s)
	);

	lnbc_sync #(
		.RST_VAL (1'b0)
	) u_ovl (
		.clk    (clk),
		.arst_n (arst_n),
		.din    (overload_sense),
		.dout   (ovl_s)
	);

	lnbc_sync #(
		.RST_VAL (1'b0)
	) u_otp (
		.clk    (clk),
		.arst_n (arst_n),
		.din    (overtemp_sense),
		.dout   (otp_s)
	);

	// =====================================================
	// Bus event detection
	wire scl_rise = scl_s & ~scl_d_q;
	wire scl_fall = ~scl_s & scl_d_q;
	wire start_c  = scl_s & scl_d_q & sda_d_q & ~sda_s;
	wire stop_c   = scl_s & scl_d_q & ~sda_d_q & sda_s;

	// Address compare with strap pin as LSB
	function addr_hit;
		input [6:0] a;
		input       sel;
		begin
			addr_hit = (a == (`LNBC_ADDR_BASE | {6'h00, sel}));  // see R2
		end
	endfunction

	// Read image: writable bits as written, flags live, don't-care zero
	function [7:0] read_image;
		input       pick;
		input [7:0] r1;
		input [7:0] r2;
		input       ovl;
		input       otp;
		begin
			if (pick)
				read_image = (r2 & `LNBC_R2_WMASK) | {6'h00, otp, 1'b0};  // see R12
			else
				read_image = (r1 & `LNBC_R1_WMASK) | {7'h00, ovl};  // see R21
		end
	endfunction

	assign img_w = read_image(pick_q, reg1_q, reg2_q, lim_flag, otp_s);  // see R14

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			scl_d_q <= 1'b1;
			sda_d_q <= 1'b1;
		end else begin
			scl_d_q <= scl_s;
			sda_d_q <= sda_s;
		end
	end

	// =====================================================
	// Protocol engine
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= ST_IDLE;
			bit_q   <= 4'h0;
			shift_q <= 8'h00;
			rw_q    <= 1'b0;
			ack_q   <= 1'b0;
			wr_q    <= 1'b0;
			sda_o   <= 1'b0;
			sda_oe  <= 1'b0;
			reg1_q  <= `LNBC_REG_RESET;  // see R9
			reg2_q  <= `LNBC_REG_RESET;
			pick_q  <= 1'b0;
		end else if (!pg_s) begin
			state_q <= ST_IDLE;  // see R15
			sda_oe  <= 1'b0;  // see R18
			wr_q    <= 1'b0;
			reg1_q  <= `LNBC_REG_RESET;
			reg2_q  <= `LNBC_REG_RESET;
			pick_q  <= 1'b0;
		end else if (start_c) begin
			state_q <= ST_ADDR;  // see R1
			bit_q   <= 4'h0;
			sda_oe  <= 1'b0;
			wr_q    <= 1'b0;
		end else if (stop_c) begin
			state_q <= ST_IDLE;  // see R3
			sda_oe  <= 1'b0;
			wr_q    <= 1'b0;
		end else begin
			case (state_q)
			ST_IDLE: begin
				sda_oe <= 1'b0;
			end
			ST_ADDR: begin
				if (scl_rise) begin
					shift_q <= {shift_q[6:0], sda_s};  // see R1
					bit_q   <= bit_q + 4'h1;
				end else if (scl_fall && bit_q == 4'h8) begin
					if (addr_hit(shift_q[7:1], sel_s)) begin
						rw_q   <= shift_q[0];
						state_q <= ST_AACK;
						sda_oe <= 1'b1;  // see R19
					end else begin
						state_q <= ST_IDLE;
					end
				end
			end
			ST_AACK: begin
				if (scl_fall) begin
					bit_q <= 4'h0;
					if (wr_q) begin
						wr_q   <= 1'b0;
						sda_oe <= 1'b0;
						state_q <= ST_WDATA;
					end else if (rw_q) begin
						state_q <= ST_RDATA;  // see R10
						shift_q <= img_w;  // see R22
						sda_oe  <= ~img_w[7];
					end else begin
						sda_oe  <= 1'b0;
						state_q <= ST_WDATA;
					end
				end
			end
			ST_WDATA: begin
				if (scl_rise) begin
					shift_q <= {shift_q[6:0], sda_s};
					bit_q   <= bit_q + 4'h1;
				end else if (scl_fall && bit_q == 4'h8) begin
					pick_q <= shift_q[`LNBC_PICK_BIT];  // see R4
					if (shift_q[`LNBC_PICK_BIT])
						reg2_q <= shift_q & `LNBC_R2_WMASK;  // see R21
					else
						reg1_q <= shift_q & `LNBC_R1_WMASK;  // see R17
					wr_q    <= 1'b1;  // see R16
					state_q <= ST_AACK;
					sda_oe  <= 1'b1;  // see R19
				end
			end
			ST_RDATA: begin
				if (scl_fall) begin
					if (bit_q == 4'h7) begin
						sda_oe  <= 1'b0;
						state_q <= ST_MACK;
					end else begin
						shift_q <= {shift_q[6:0], 1'b0};
						sda_oe  <= ~shift_q[6];  // see R10
						bit_q   <= bit_q + 4'h1;
					end
				end
			end
			ST_MACK: begin
				if (scl_rise) begin
					ack_q <= ~sda_s;
				end else if (scl_fall) begin
					bit_q <= 4'h0;
					if (ack_q) begin
						state_q <= ST_RDATA;  // see R11
						shift_q <= img_w;
						sda_oe  <= ~img_w[7];
					end else begin
						state_q <= ST_IDLE;  // see R11
					end
				end
			end
			default: begin
				state_q <= ST_IDLE;
			end
			endcase
		end
	end

	// =====================================================
	// Overload protection
	lnbc_limit #(
		.OFF_CYCLES (OFF_CYCLES),
		.ON_CYCLES  (ON_CYCLES)
	) u_limit (
		.clk         (clk),
		.arst_n      (arst_n),
		.enable      (reg1_q[`LNBC_R1_PWR] & pg_s),
		.static_mode (reg1_q[`LNBC_R1_CLAMP]),
		.overload    (ovl_s),
		.flag_q      (lim_flag),
		.out_off_q   (lim_off)
	);

	// =====================================================
	// Control outputs, all registered
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			output_power_on     <= 1'b0;
			high_voltage_pick   <= 1'b0;
			cable_drop_boost    <= 1'b0;
			tone_on             <= 1'b0;
			static_clamp_select <= 1'b0;
			limit_range_pick    <= 1'b0;
			second_output_on    <= 1'b0;
			overload_flag       <= 1'b0;
			overtemp_flag       <= 1'b0;
		end else begin
			// Power gated by temperature and retry shutdown
			output_power_on     <= reg1_q[`LNBC_R1_PWR] & ~otp_s & ~lim_off;  // see R8
			high_voltage_pick   <= reg1_q[`LNBC_R1_HIGHV];  // see R5
			cable_drop_boost    <= reg1_q[`LNBC_R1_CABLE];  // see R5
			tone_on             <= reg1_q[`LNBC_R1_TONE] | gate_s;  // see R6
			static_clamp_select <= reg1_q[`LNBC_R1_CLAMP];  // see R7
			limit_range_pick    <= reg1_q[`LNBC_R1_RANGE];
			second_output_on    <= reg2_q[`LNBC_R2_OUT2];
			overload_flag       <= lim_flag;  // see R14
			overtemp_flag       <= otp_s;  // see R13
		end
	end
endmodule

/* File: verif/lnbc_monitor.sv */
// Checker for the LNB supply control interface
`timescale 1ns/1ns
module lnbc_monitor (
	input wire clk,
	input wire arst_n,
	input wire scl_i,
	input wire sda_i,
	input wire sda_o,
	input wire sda_oe,
	input wire addr_sel,
	input wire power_good,
	input wire tone_gate_input,
	input wire overload_sense,
	input wire overtemp_sense,
	input wire output_power_on,
	input wire high_voltage_pick,
	input wire cable_drop_boost,
	input wire tone_on,
	input wire static_clamp_select,
	input wire limit_range_pick,
	input wire second_output_on,
	input wire overload_flag,
	input wire overtemp_flag
);
	// =====
	// Assertions
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	a_open_drain: assert property (sda_oe |-> !sda_o)
		else $error("sda driven high");
	a_oe_pg_low: assert property ((!power_good)[*5] |-> !sda_oe)
		else $error("ack while power bad");
	a_regs_pg_low: assert property ((!power_good)[*5] |->
		!(output_power_on | high_voltage_pick | cable_drop_boost | static_clamp_select
		| limit_range_pick | second_output_on))
		else $error("settings kept while power bad");
	a_oe_scl_low: assert property ($rose(sda_oe) |-> !scl_i)
		else $error("sda changed while scl high");
	a_pwr_overtemp: assert property (overtemp_sense[*5] |-> !output_power_on && overtemp_flag)
		else $error("power on while hot");
	a_tone_gate: assert property (tone_gate_input[*5] |-> tone_on)
		else $error("tone gate lost");
	a_static_flag: assert property (
		(static_clamp_select && output_power_on && overload_sense)[*5] |-> overload_flag)
		else $error("overload flag low");
	a_dyn_off: assert property (!static_clamp_select && $rose(overload_flag)
		|-> ##[0:3] !output_power_on)
		else $error("output kept on");
	cover property ($rose(sda_oe));
	cover property ($rose(overload_flag) && static_clamp_select);
	cover property ($fell(output_power_on) && !static_clamp_select);
endmodule
bind lnbc_ctrl lnbc_monitor u_mon (.*);

/* File: verif/lnbc_host.sv */
// I2C bus master model for the host processor side
`timescale 1ns/1ns
module lnbc_host (
	input  wire  clk,
	input  wire  sda,
	output logic scl,
	output logic sdm
);
	// =====
	// Bus cycles, SCL stands high between frames
	initial begin
		scl = 1;
		sdm = 1;
	end
	task w(input int n);
		repeat (n) @(posedge clk) #1;
	endtask
	task st;
		begin
			sdm = 1;
			w(1);
			scl = 1;
			w(4);
			sdm = 0;
			w(4);
			scl = 0;
		end
	endtask
	task sp;
		begin
			w(1);
			sdm = 0;
			w(3);
			scl = 1;
			w(4);
			sdm = 1;
			w(4);
		end
	endtask
	task bt(input logic b, output logic r);
		begin
			w(1);
			sdm = b;
			w(3);
			scl = 1;
			w(2);
			r = sda;
			w(2);
			scl = 0;
		end
	endtask
	task xb(input logic [7:0] d, input logic m, output logic [7:0] q, output logic k);
		int i;
		begin
			for (i = 7; i >= 0; i--) bt(d[i], q[i]);
			bt(m, k);
		end
	endtask
endmodule

/* File: verif/lnbc_tb.sv */
// Self-checking bench for the LNB supply control interface
`timescale 1ns/1ns
module testbench;
	logic clk, arst_n, addr_sel, power_good, tone_gate_input, overload_sense, overtemp_sense;
	wire  scl_i, sdm, sda_i, sda_o, sda_oe, output_power_on, high_voltage_pick, cable_drop_boost;
	wire  tone_on, static_clamp_select, limit_range_pick, second_output_on, overload_flag;
	wire  overtemp_flag;
	int   bad_count, samples_checked, r1, r2, pk, ov, i, j, s;
	logic [7:0] q;
	logic k;
	logic [7:0] tbl [6] = '{8'h7F, 8'hFF, 8'h04, 8'h08, 8'h80, 8'h00};
	// =====
	// Pull-up on SDA with open-drain device
	assign sda_i = sdm & !(sda_oe & !sda_o);
	lnbc_host u_host (.clk(clk), .sda(sda_i), .scl(scl_i), .sdm(sdm));
	lnbc_ctrl #(.OFF_CYCLES(50), .ON_CYCLES(10)) u_dut (.*);
	task w(input int n);
		repeat (n) @(posedge clk) #1;
	endtask
	task chk(input logic [7:0] g, input logic [7:0] e);
		begin
			samples_checked++;
			if (g !== e) begin
				bad_count++;
				$display("wrong value at %0t: %h not %h", $time, g, e);
			end
		end
	endtask
	function int hit(input logic [6:0] a);
		return power_good && a == {6'h04, addr_sel};
	endfunction
	task wr(input logic [6:0] a, input logic [7:0] d);
		begin
			u_host.st();
			u_host.xb({a, 1'h0}, 1'h1, q, k);
			chk(k, !hit(a));
			if (hit(a)) begin
				u_host.xb(d, 1'h1, q, k);
				chk(k, 8'h00);
				pk = d[7];
				if (pk) r2 = d & 8'h04;
				else r1 = d & 8'h7E;
			end
			u_host.sp();
		end
	endtask
	task rd;
		begin
			u_host.st();
			u_host.xb({6'h04, addr_sel, 1'h1}, 1'h1, q, k);
			chk(k, 8'h00);
			for (i = 0; i < 2; i++) begin
				u_host.xb(8'hFF, i == 1, q, k);
				chk(q, pk ? r2 | overtemp_sense << 1 : r1 | ov);
			end
			u_host.sp();
		end
	endtask
	task cko;
		begin
			w(6);
			chk({static_clamp_select, limit_range_pick, tone_on, cable_drop_boost, high_voltage_pick,
				output_power_on, second_output_on}, {r1[6:5], r1[4] | tone_gate_input, r1[3:2],
				r1[1] & !overtemp_sense, r2[2]});
			chk({overload_flag, overtemp_flag}, {ov[0], overtemp_sense});
		end
	endtask
	task stop_test;
		begin
			$display("checked %0d, wrong %0d", samples_checked, bad_count);
			if (bad_count == 0 && samples_checked > 0) begin
				$display("STATUS OK");
			end else begin
				$display("STATUS NOT OK");
			end
			$finish;
		end
	endtask
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	initial begin
		#400000;
		bad_count++;
		stop_test();
	end
	initial begin
		{arst_n, addr_sel, tone_gate_input, overload_sense, overtemp_sense} = 5'h00;
		power_good = 1;
		s = $urandom(85126);
		w(6);
		chk({output_power_on, tone_on, overload_flag, sda_oe}, 8'h00);
		arst_n = 1;
		w(4);
		for (j = 0; j < 22; j++) begin
			addr_sel = $urandom;
			tone_gate_input = $urandom;
			overtemp_sense = $urandom;
			wr(j % 5 == 4 ? $urandom : {6'h04, addr_sel}, j < 6 ? tbl[j] : $urandom);
			rd();
			cko();
		end
		$display("register test done");
		power_good = 0;
		w(4);
		wr({6'h04, addr_sel}, 8'h7E);
		r1 = 0;
		r2 = 0;
		pk = 0;
		cko();
		power_good = 1;
		w(4);
		$display("power good test done");
		overtemp_sense = 0;
		wr({6'h04, addr_sel}, 8'h42);
		overload_sense = 1;
		ov = 1;
		cko();
		rd();
		overload_sense = 0;
		ov = 0;
		cko();
		wr({6'h04, addr_sel}, 8'h02);
		overload_sense = 1;
		w(6);
		chk({output_power_on, overload_flag}, 8'h01);
		overload_sense = 0;
		w(90);
		chk({output_power_on, overload_flag}, 8'h02);
		$display("overload test done");
		stop_test();
	end
endmodule
